// file: hw/mwx_top.sv
// multi-lane write command front end with its write fifo
`timescale 1ns/1ps
`include "mwx_defs.svh"

module mwx_fifo #(
   parameter int WIDTH = `MWX_ENTRY_W,
   parameter int DEPTH = `MWX_FIFO_DEPTH
) (
   input  wire logic             clk,
   input  wire logic             reset,
   input  wire logic             clk_en,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   logic [AW-1:0]    next_wr_ptr;
   logic [AW-1:0]    next_rd_ptr;
   logic [AW:0]      next_count;
   logic             next_out_valid;
   logic [WIDTH-1:0] next_out_data;
   logic             push;
   logic             load;

   always_comb begin
      in_ready       = (count != (AW+1)'(DEPTH));
      push           = in_valid & in_ready;
      load           = (count != '0) & (~out_valid | out_ready);
      next_wr_ptr    = push ? wr_ptr + 1'b1 : wr_ptr;
      next_rd_ptr    = load ? rd_ptr + 1'b1 : rd_ptr;
      next_count     = count + (AW+1)'(push) - (AW+1)'(load);
      next_out_valid = load | (out_valid & ~out_ready);
      next_out_data  = load ? mem[rd_ptr] : out_data;
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         wr_ptr    <= '0;
         rd_ptr    <= '0;
         count     <= '0;
         out_valid <= 1'b0;
         out_data  <= '0;
      end else if (clk_en) begin
         wr_ptr    <= next_wr_ptr;
         rd_ptr    <= next_rd_ptr;
         count     <= next_count;
         out_valid <= next_out_valid;
         out_data  <= next_out_data;
      end
   end

   always_ff @(posedge clk) begin
      if (clk_en && push) begin
         mem[wr_ptr] <= in_data;
      end
   end
endmodule : mwx_fifo

module mwx_top (
   input  wire logic             clk,
   input  wire logic             reset,
   input  wire logic             clk_en,
   input  wire logic             cs_n_pin,
   input  wire logic             sck_pin,
   input  wire logic [3:0]       io_in,
   output logic      [3:0]       io_out,
   output logic      [3:0]       io_oe,
   input  wire logic [7:0]       status_reg_one,
   output logic                  wr_valid,
   input  wire logic             wr_ready,
   output mwx_pkg::mwx_wr_s      wr_entry,
   output logic                  continuous_active,
   output logic                  mode3_refused,
   output logic                  overrun
);
   logic                  cs_s1, cs_s2, cs_s3;
   logic                  sck_s1, sck_s2, sck_s3;
   logic [3:0]            io_s1, io_s2;
   mwx_pkg::mwx_state_e   state, next_state;
   logic [7:0]            cmd, next_cmd;
   logic [31:0]           shreg, next_shreg;
   logic [5:0]            cnt, next_cnt;
   logic [`MWX_AW-1:0]    addr, next_addr;
   logic                  next_cont;
   logic [7:0]            cont_cmd, next_cont_cmd;
   mwx_pkg::mwx_wr_s      pend, next_pend;
   logic                  pend_valid, next_pend_valid;
   logic                  next_overrun;
   logic                  next_mode3;
   logic                  clk_high_at_sel, next_clk_high_at_sel;
   logic                  wel_ok, next_wel_ok;
   logic                  fifo_in_ready;
   logic                  rise, fall, cs_fall, sample;
   logic [5:0]            w;

   function automatic logic is_ddr(input logic [7:0] op);
      return (op == `MWX_OP_DDR_BURST) || (op == `MWX_OP_DDR_FOUR);
   endfunction : is_ddr

   function automatic logic is_known(input logic [7:0] op);
      return is_ddr(op) || (op == `MWX_OP_TWO_DATA) || (op == `MWX_OP_TWO_AD) ||
             (op == `MWX_OP_FOUR_DATA) || (op == `MWX_OP_FOUR_AD);
   endfunction : is_known

   // bits per sampled edge for the current phase
   function automatic logic [5:0] lane_w(input mwx_pkg::mwx_state_e st, input logic [7:0] op);
      logic [5:0] r;
      r = `MWX_W1;
      if (st == mwx_pkg::MWX_ADDR || st == mwx_pkg::MWX_MODE) begin
         if (op == `MWX_OP_TWO_AD) r = `MWX_W2;                                     // see R9
         else if (op == `MWX_OP_FOUR_AD || is_ddr(op)) r = `MWX_W4;                  // see R13
         else r = `MWX_W1;                                                           // see R7
      end else if (st == mwx_pkg::MWX_DATA) begin
         if (op == `MWX_OP_TWO_DATA || op == `MWX_OP_TWO_AD) r = `MWX_W2;            // see R8
         else r = `MWX_W4;                                                           // see R11
      end
      return r;
   endfunction : lane_w

   // msb first: lane 3 (or highest used) carries the earliest bit
   function automatic logic [31:0] shift_in(input logic [31:0] s, input logic [5:0] wd, input logic [3:0] io);
      logic [31:0] r;
      r = {s[30:0], io[0]};
      if (wd == `MWX_W2) r = {s[29:0], io[1], io[0]};                                // see R10
      else if (wd == `MWX_W4) r = {s[27:0], io[3], io[2], io[1], io[0]};              // see R12
      return r;
   endfunction : shift_in

   // two-stage synchronisers, third stage only for edge finding
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cs_s1  <= 1'b1;
         cs_s2  <= 1'b1;
         cs_s3  <= 1'b1;
         sck_s1 <= 1'b0;
         sck_s2 <= 1'b0;
         sck_s3 <= 1'b0;
         io_s1  <= 4'h0;
         io_s2  <= 4'h0;
      end else if (clk_en) begin
         cs_s1  <= cs_n_pin;
         cs_s2  <= cs_s1;
         cs_s3  <= cs_s2;
         sck_s1 <= sck_pin;
         sck_s2 <= sck_s1;
         sck_s3 <= sck_s2;
         io_s1  <= io_in;
         io_s2  <= io_s1;
      end
   end

   always_comb begin
      rise    = sck_s2 & ~sck_s3;
      fall    = ~sck_s2 & sck_s3;
      cs_fall = ~cs_s2 & cs_s3;
      w       = lane_w(state, cmd);
      sample  = rise | (fall & is_ddr(cmd) & ((cnt & `MWX_W4) != 6'h00) & (state == mwx_pkg::MWX_ADDR ||
                state == mwx_pkg::MWX_MODE || state == mwx_pkg::MWX_DATA));                   // see R16, R22
      next_state           = state;
      next_cmd             = cmd;
      next_shreg           = shreg;
      next_cnt             = cnt;
      next_addr            = addr;
      next_cont            = continuous_active;
      next_cont_cmd        = cont_cmd;
      next_pend            = pend;
      next_pend_valid      = pend_valid & ~fifo_in_ready;
      next_overrun         = overrun;
      next_mode3           = mode3_refused;
      next_clk_high_at_sel = clk_high_at_sel;
      next_wel_ok          = wel_ok;
      if (cs_s2) begin
         next_state = mwx_pkg::MWX_IDLE;
      end else if (cs_fall) begin
         next_cnt             = 6'h00;
         next_clk_high_at_sel = sck_s2;
         next_wel_ok          = status_reg_one[`MWX_WEL_BIT];                      // see R19
         next_mode3           = 1'b0;
         if (continuous_active) begin
            next_cmd = cont_cmd;                                                     // see R2, R23
            if (is_ddr(cont_cmd) && sck_s2) begin
               next_state = mwx_pkg::MWX_IGNORE;                                     // see R3, R18
               next_mode3 = 1'b1;
            end else begin
               next_state = mwx_pkg::MWX_ADDR;
            end
         end else begin
            next_state = mwx_pkg::MWX_OPC;
         end
      end else if (sample) begin
         next_shreg = shift_in(shreg, w, io_s2);
         next_cnt   = cnt + w;
         unique case (state)
            mwx_pkg::MWX_OPC: begin
               if (next_cnt == `MWX_OPC_BITS) begin
                  next_cnt = 6'h00;
                  next_cmd = next_shreg[7:0];
                  if (!is_known(next_shreg[7:0])) begin
                     next_state = mwx_pkg::MWX_IGNORE;
                  end else if (is_ddr(next_shreg[7:0]) && clk_high_at_sel) begin
                     next_state = mwx_pkg::MWX_IGNORE;                               // see R3, R18
                     next_mode3 = 1'b1;
                  end else begin
                     next_state = mwx_pkg::MWX_ADDR;
                  end
               end
            end
            mwx_pkg::MWX_ADDR: begin
               if (next_cnt == `MWX_ADDR_BITS) begin
                  next_cnt   = 6'h00;
                  next_addr  = next_shreg[`MWX_AW-1:0];                              // see R21
                  next_state = mwx_pkg::MWX_MODE;
               end
            end
            mwx_pkg::MWX_MODE: begin
               if (next_cnt == `MWX_BYTE_BITS) begin
                  next_cnt      = 6'h00;
                  next_cont_cmd = cmd;                                               // see R23
                  if (is_ddr(cmd)) begin
                     next_cont = (next_shreg[7:0] == `MWX_MODE_DDR);                 // see R1, R17
                  end else begin
                     next_cont = (next_shreg[7:4] == `MWX_MODE_HI);                  // see R14, R15
                  end
                  next_state = mwx_pkg::MWX_DATA;
               end
            end
            mwx_pkg::MWX_DATA: begin
               if (next_cnt == `MWX_BYTE_BITS) begin
                  next_cnt = 6'h00;
                  if (wel_ok) begin                                                  // see R4, R5
                     if (pend_valid && !fifo_in_ready) begin
                        next_overrun = 1'b1;
                     end else begin
                        next_pend.addr  = addr;
                        next_pend.data  = next_shreg[7:0];
                        next_pend_valid = 1'b1;
                     end
                  end
                  next_addr = addr + 1'b1;                                           // see R20
               end
            end
            mwx_pkg::MWX_IDLE, mwx_pkg::MWX_IGNORE: begin
               next_state = state;
            end
         endcase
      end
   end

   // the latch is only read here and never cleared by a write; see R6
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state             <= mwx_pkg::MWX_IDLE;
         cmd               <= 8'h00;
         shreg             <= 32'h0000_0000;
         cnt               <= 6'h00;
         addr              <= '0;
         continuous_active <= 1'b0;
         cont_cmd          <= 8'h00;
         pend              <= '0;
         pend_valid        <= 1'b0;
         overrun           <= 1'b0;
         mode3_refused     <= 1'b0;
         clk_high_at_sel   <= 1'b0;
         wel_ok            <= 1'b0;
         io_out            <= 4'h0;
         io_oe             <= 4'h0;
      end else if (clk_en) begin
         state             <= next_state;
         cmd               <= next_cmd;
         shreg             <= next_shreg;
         cnt               <= next_cnt;
         addr              <= next_addr;
         continuous_active <= next_cont;
         cont_cmd          <= next_cont_cmd;
         pend              <= next_pend;
         pend_valid        <= next_pend_valid;
         overrun           <= next_overrun;
         mode3_refused     <= next_mode3;
         clk_high_at_sel   <= next_clk_high_at_sel;
         wel_ok            <= next_wel_ok;
         io_out            <= 4'h0;
         io_oe             <= 4'h0;
      end
   end

   mwx_fifo #(
      .WIDTH (`MWX_ENTRY_W),
      .DEPTH (`MWX_FIFO_DEPTH)
   ) u_fifo (
      .clk       (clk),
      .reset     (reset),
      .clk_en    (clk_en),
      .in_valid  (pend_valid),
      .in_ready  (fifo_in_ready),
      .in_data   (pend),
      .out_valid (wr_valid),
      .out_ready (wr_ready),
      .out_data  (wr_entry)
   );
endmodule : mwx_top

// file: hw/mwx_defs.svh
// constants for the multi-lane write command front end
// Notes on behaviour
// R1: opcode ddh, mode a5h enters continuous mode
// R2: continuous double-rate: next transaction skips opcode
// R3: ddh refused when clock idles high
// R4: ddh writes only while latch set
// R5: a2h writes only while latch set
// R6: writes never clear the write enable latch
// R7: a2h opcode, address, mode on input line
// R8: a2h data two lanes, bit 7 on lane1
// R9: a1h address and mode on two lanes
// R10: a1h data two lanes, bit 7 first
// R11: 32h header on input line, then four lanes
// R12: 32h data four lanes, high nibble first
// R13: d2h address and data on four lanes
// R14: upper mode nibble ah enters continuous mode
// R15: other mode byte leaves continuous mode
// R16: d1h is d2h on both clock edges
// R17: d1h continuous only with mode a5h
// R18: d1h refused when clock idles high
// R19: latch is status register one bit 1
// R20: address increments, wraps after 3ffffh
// R21: only 18 address bits are kept
// R22: double rate: rising nibble then falling nibble
// R23: continuous mode reuses the entering command's format
`ifndef MWX_DEFS_SVH
`define MWX_DEFS_SVH
`define MWX_OP_DDR_BURST 8'hdd
`define MWX_OP_TWO_DATA  8'ha2
`define MWX_OP_TWO_AD    8'ha1
`define MWX_OP_FOUR_DATA 8'h32
`define MWX_OP_FOUR_AD   8'hd2
`define MWX_OP_DDR_FOUR  8'hd1
`define MWX_MODE_DDR     8'ha5
`define MWX_MODE_HI      4'ha
`define MWX_OPC_BITS     6'h08
`define MWX_ADDR_BITS    6'h18
`define MWX_BYTE_BITS    6'h08
`define MWX_W1           6'h01
`define MWX_W2           6'h02
`define MWX_W4           6'h04
`define MWX_AW           18
`define MWX_WEL_BIT      1
`define MWX_FIFO_DEPTH   8
`define MWX_ENTRY_W      26
`endif

// file: hw/mwx_pkg.sv
// types for the multi-lane write command front end
`include "mwx_defs.svh"
package mwx_pkg;
   typedef enum logic [2:0] {MWX_IDLE, MWX_OPC, MWX_ADDR, MWX_MODE, MWX_DATA, MWX_IGNORE} mwx_state_e;
   typedef struct packed {
      logic [`MWX_AW-1:0] addr;
      logic [7:0]         data;
   } mwx_wr_s;
endpackage : mwx_pkg

// file: verif/mwx_checker.sv
// port assertions for the multi-lane write front end
`timescale 1ns/1ps
`include "mwx_defs.svh"
module mwx_checker (
   input logic             clk,
   input logic             reset,
   input logic             cs_n_pin,
   input logic             sck_pin,
   input logic [3:0]       io_oe,
   input logic [7:0]       status_reg_one,
   input logic             wr_valid,
   input logic             wr_ready,
   input mwx_pkg::mwx_wr_s wr_entry,
   input logic             continuous_active,
   input logic             mode3_refused
);
   logic [7:0] quiet_cnt;
   logic [7:0] next_quiet_cnt;
   // cycles since the write enable latch was last seen set
   always_comb begin
      next_quiet_cnt = quiet_cnt;
      if (status_reg_one[`MWX_WEL_BIT]) next_quiet_cnt = 8'h00;
      else if (quiet_cnt != 8'hff) next_quiet_cnt = quiet_cnt + 8'h01;
   end
   always_ff @(posedge clk or posedge reset) begin
      if (reset) quiet_cnt <= 8'h00;
      else quiet_cnt <= next_quiet_cnt;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   a_lanes_not_driven: assert property (io_oe == 4'h0)
      else $error("lane driven by block");
   a_entry_holds: assert property (wr_valid && !wr_ready |=> wr_valid && $stable(wr_entry))
      else $error("entry changed while stalled");
   a_write_needs_latch: assert property ($rose(wr_valid) |-> quiet_cnt < 8'h64)
      else $error("write without latch");
   a_write_in_frame: assert property ($rose(wr_valid) |-> !$past(cs_n_pin, 8))
      else $error("write outside frame");
   a_refused_on_high: assert property ($rose(mode3_refused) |-> $past(sck_pin, 2) && !$past(cs_n_pin, 2))
      else $error("refusal without high clock");
   a_refused_stands: assert property (mode3_refused && cs_n_pin && $past(cs_n_pin) && $past(cs_n_pin, 2)
      |=> mode3_refused) else $error("refusal dropped early");
   a_refused_keeps_mode: assert property (mode3_refused && $past(mode3_refused)
      |-> $stable(continuous_active)) else $error("refused frame changed mode");
   a_mode_in_frame: assert property ($changed(continuous_active) |-> !$past(cs_n_pin, 3))
      else $error("mode changed outside frame");
endmodule : mwx_checker

bind mwx_top mwx_checker u_chk (.clk(clk), .reset(reset), .cs_n_pin(cs_n_pin), .sck_pin(sck_pin), .io_oe(io_oe),
   .status_reg_one(status_reg_one), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_entry(wr_entry),
   .continuous_active(continuous_active), .mode3_refused(mode3_refused));

// file: verif/mwx_host.sv
// host serial controller model for multi-lane write frames
`timescale 1ns/1ps
module mwx_host (
   input  logic       clk,
   output logic       cs_n_pin,
   output logic       sck_pin,
   output logic [3:0] io
);
   initial begin
      cs_n_pin = 1'b1;
      sck_pin  = 1'b0;
      io       = 4'h0;
   end
   // n bits msb first on w lanes, idle lanes toggle
   task automatic send(input logic [31:0] v, input int n, input int w, input bit dr);
      logic [3:0] m;
      int         i;
      m = 4'((1 << w) - 1);
      for (i = n; i > 0; i = i - (dr ? 8 : w)) begin
         io = (4'(v >> (i - w)) & m) | (~io & ~m);
         #(dr ? 80 : 160) sck_pin = 1'b1;
         if (dr) begin
            #80 io = 4'(v >> (i - 8));
            #80 sck_pin = 1'b0;
            #80;
         end else begin
            #160 sck_pin = 1'b0;
         end
      end
   endtask : send
   // idle_high starts the frame with the clock high
   task automatic frame(input bit opc_on, input logic [7:0] opc, input bit idle_high, input logic [23:0] addr,
                        input logic [7:0] mode, input int aw, input int dw, input bit dr, input int nb,
                        input logic [7:0] d0);
      int k;
      @(posedge clk);
      #1 sck_pin = idle_high;
      #200 cs_n_pin = 1'b0;
      #200 sck_pin = 1'b0;
      if (opc_on) send(32'(opc), 8, 1, 1'b0);
      send(32'(addr), 24, aw, dr);
      send(32'(mode), 8, aw, dr);
      for (k = 0; k < nb; k++) send(32'(d0 + 8'(k)), 8, dw, dr);
      #160 cs_n_pin = 1'b1;
      io = ~io;
      #400;
   endtask : frame
endmodule : mwx_host

// file: verif/test_mwx_top.sv
// self-checking bench for the multi-lane write front end
`timescale 1ns/1ps
`include "mwx_defs.svh"
module test_mwx_top;
   logic             clk = 1'b0;
   logic             reset = 1'b1;
   logic             clk_en = 1'b1;
   logic             cs_n_pin;
   logic             sck_pin;
   logic [3:0]       host_io;
   logic [3:0]       io_in;
   logic [3:0]       io_out;
   logic [3:0]       io_oe;
   logic [7:0]       status_reg_one = 8'h02;
   logic             wr_valid;
   logic             wr_ready = 1'b1;
   mwx_pkg::mwx_wr_s wr_entry;
   logic             continuous_active;
   logic             mode3_refused;
   logic             overrun;
   mwx_pkg::mwx_wr_s q[$];
   int               err_count = 0;
   int               checks_done = 0;
   logic [7:0]       opc_t [6] = '{`MWX_OP_TWO_DATA, `MWX_OP_TWO_AD, `MWX_OP_FOUR_DATA, `MWX_OP_FOUR_AD,
                                   `MWX_OP_DDR_FOUR, `MWX_OP_DDR_BURST};
   int               aw_t [6] = '{1, 2, 1, 4, 4, 4};
   int               dw_t [6] = '{2, 2, 4, 4, 4, 4};
   bit               dr_t [6] = '{0, 0, 0, 0, 1, 1};
   always #20 clk = ~clk;
   assign io_in = (io_oe & io_out) | (~io_oe & host_io);
   mwx_top DUT (.clk(clk), .reset(reset), .clk_en(clk_en), .cs_n_pin(cs_n_pin), .sck_pin(sck_pin), .io_in(io_in),
      .io_out(io_out), .io_oe(io_oe), .status_reg_one(status_reg_one), .wr_valid(wr_valid), .wr_ready(wr_ready),
      .wr_entry(wr_entry), .continuous_active(continuous_active), .mode3_refused(mode3_refused), .overrun(overrun));
   mwx_host u_host (.clk(clk), .cs_n_pin(cs_n_pin), .sck_pin(sck_pin), .io(host_io));
   always @(posedge clk) begin
      if (wr_valid === 1'b1 && wr_ready === 1'b1) q.push_back(wr_entry);
   end
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : complete_run
   task automatic check(input bit ok, input string msg);
      checks_done++;
      if (!ok) begin
         err_count++;
         $display("[ERR] %0t %s", $time, msg);
      end
   endtask : check
   task automatic expect_bytes(input logic [17:0] a, input logic [7:0] d, input int n);
      int k;
      for (k = 0; k < 60 && q.size() < n; k++) @(posedge clk);
      if (q.size() < n) begin
         check(1'b0, "entries missing");
         complete_run();
      end
      for (k = 0; k < n; k++) check(q[k] === {a + 18'(k), d + 8'(k)}, "entry mismatch");
      check(q.size() == n, "entry count");
      q.delete();
   endtask : expect_bytes
   task automatic t_formats();
      int c;
      for (c = 0; c < 6; c++) begin
         u_host.frame(1'b1, opc_t[c], 1'b0, 24'hffffff, 8'h00, aw_t[c], dw_t[c], dr_t[c], 2,
                      8'h3c + 8'(c));
         expect_bytes(18'h3ffff, 8'h3c + 8'(c), 2);
         check(continuous_active === 1'b0, "mode armed by 00h");
         check(io_out === 4'h0 && io_oe === 4'h0, "lanes driven");
      end
      $display("test formats done");
   endtask : t_formats
   task automatic t_continuous();
      int c;
      for (c = 0; c < 6; c++) begin
         u_host.frame(1'b1, opc_t[c], 1'b0, 24'h012340, dr_t[c] ? `MWX_MODE_DDR : 8'ha3, aw_t[c], dw_t[c],
                      dr_t[c], 1, 8'h11);
         expect_bytes(18'h12340, 8'h11, 1);
         check(continuous_active === 1'b1, "mode not armed");
         u_host.frame(1'b0, 8'h00, 1'b0, 24'h000100 + 24'(c), 8'h5a, aw_t[c], dw_t[c],
                      dr_t[c], 1, 8'h77);
         expect_bytes(18'h00100 + 18'(c), 8'h77, 1);
         check(continuous_active === 1'b0, "mode not left");
      end
      u_host.frame(1'b1, `MWX_OP_DDR_FOUR, 1'b0, 24'h000000, 8'ha3, 4, 4, 1'b1, 1, 8'h55);
      expect_bytes(18'h00000, 8'h55, 1);
      check(continuous_active === 1'b0, "a3h armed double rate");
      $display("test continuous done");
   endtask : t_continuous
   task automatic t_latch();
      @(posedge clk);
      #1 status_reg_one = 8'hfd;
      repeat (110) @(posedge clk);
      u_host.frame(1'b1, `MWX_OP_TWO_DATA, 1'b0, 24'h000010, 8'h00, 1, 2, 1'b0, 2, 8'h21);
      u_host.frame(1'b1, `MWX_OP_DDR_BURST, 1'b0, 24'h000010, 8'h00, 4, 4, 1'b1, 2, 8'h21);
      expect_bytes(18'h00000, 8'h00, 0);
      @(posedge clk);
      #1 status_reg_one = 8'h02;
      $display("test latch done");
   endtask : t_latch
   task automatic t_mode3();
      int c;
      for (c = 4; c < 6; c++) begin
         u_host.frame(1'b1, opc_t[c], 1'b1, 24'h000100, 8'h00, 4, 4, 1'b1, 1, 8'h99);
         check(mode3_refused === 1'b1, "mode 3 accepted");
         expect_bytes(18'h00000, 8'h00, 0);
      end
      u_host.frame(1'b1, 8'h02, 1'b0, 24'h000100, 8'ha0, 1, 1, 1'b0, 1, 8'h99);
      check(continuous_active === 1'b0, "unknown opcode armed mode");
      expect_bytes(18'h00000, 8'h00, 0);
      u_host.frame(1'b1, `MWX_OP_DDR_FOUR, 1'b0, 24'h000100, `MWX_MODE_DDR, 4, 4, 1'b1, 1, 8'h99);
      expect_bytes(18'h00100, 8'h99, 1);
      u_host.frame(1'b0, 8'h00, 1'b1, 24'h000100, 8'h00, 4, 4, 1'b1, 1, 8'h99);
      check(mode3_refused === 1'b1 && continuous_active === 1'b1, "opcode-free mode 3 accepted");
      expect_bytes(18'h00000, 8'h00, 0);
      u_host.frame(1'b0, 8'h00, 1'b0, 24'h000180, 8'h5a, 4, 4, 1'b1, 1, 8'h98);
      expect_bytes(18'h00180, 8'h98, 1);
      check(continuous_active === 1'b0, "double rate mode not left");
      u_host.frame(1'b1, `MWX_OP_FOUR_AD, 1'b0, 24'h000200, 8'h00, 4, 4, 1'b0, 1, 8'h42);
      expect_bytes(18'h00200, 8'h42, 1);
      check(mode3_refused === 1'b0, "refusal kept");
      $display("test mode3 done");
   endtask : t_mode3
   task automatic t_stall();
      int k;
      @(posedge clk);
      #1 wr_ready = 1'b0;
      u_host.frame(1'b1, `MWX_OP_FOUR_AD, 1'b0, 24'h000300, 8'h00, 4, 4, 1'b0, 12, 8'h80);
      check(wr_valid === 1'b1 && overrun === 1'b1, "full buffer not refused");
      @(posedge clk);
      #1 wr_ready = 1'b1;
      repeat (20) @(posedge clk);
      for (k = 0; k < 8; k++) check(q[k] === {18'h00300 + 18'(k), 8'h80 + 8'(k)}, "drain order");
      check(q.size() >= 8 && q.size() < 12, "drain count");
      q.delete();
      $display("test stall done");
   endtask : t_stall
   task automatic t_reset();
      @(posedge clk);
      #1 reset = 1'b1;
      repeat (2) @(posedge clk);
      #1 reset = 1'b0;
      check(overrun === 1'b0 && wr_valid === 1'b0 && continuous_active === 1'b0, "reset left state");
      repeat (4) @(posedge clk);
      #1 clk_en = 1'b0;
      u_host.frame(1'b1, `MWX_OP_FOUR_AD, 1'b0, 24'h000400, 8'h00, 4, 4, 1'b0, 1, 8'h65);
      @(posedge clk);
      #1 clk_en = 1'b1;
      u_host.frame(1'b1, `MWX_OP_FOUR_AD, 1'b0, 24'h000400, 8'h00, 4, 4, 1'b0, 1, 8'h66);
      expect_bytes(18'h00400, 8'h66, 1);
      $display("test reset done");
   endtask : t_reset
   initial begin
      repeat (16) @(posedge clk);
      #1 reset = 1'b0;
      repeat (4) @(posedge clk);
      t_formats();
      t_continuous();
      t_latch();
      t_mode3();
      t_stall();
      t_reset();
      complete_run();
   end
endmodule : test_mwx_top
